// File: boot_rx.sv
// Purpose: Serial boot link receiver, one start, eight data, one stop
// Assumes: rxd synchronous to clk_sys, idle high
// Notes:   Frame error when the last data bit is not 0 or stop is low
`timescale 1ns/1ns
module boot_rx
   import fsp_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic       rxd,
   output logic [7:0]      rx_data_r,
   output logic            rx_valid_r,
   output logic            rx_err_r
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
   rx_state_t         st_r;
   logic [BAUD_W-1:0] tick_r;
   logic [2:0]        bit_r;
   logic [7:0]        sh_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= RX_IDLE;
         tick_r     <= '0;
         bit_r      <= '0;
         sh_r       <= '0;
         rx_data_r  <= '0;
         rx_valid_r <= 1'b0;
         rx_err_r   <= 1'b0;
      end else begin
         rx_valid_r <= 1'b0;
         rx_err_r   <= 1'b0;
         if (tick_r != '0) begin
            tick_r <= tick_r - BAUD_W'(1);
         end else begin
            case (st_r)
               RX_IDLE: if (enable && !rxd) begin
                  st_r   <= RX_START;
                  tick_r <= HALF_LAST;
               end
               RX_START: begin
                  st_r   <= rxd ? RX_IDLE : RX_DATA;
                  tick_r <= BIT_LAST;
                  bit_r  <= '0;
               end
               RX_DATA: begin
                  sh_r   <= {rxd, sh_r[7:1]};
                  tick_r <= BIT_LAST;
                  bit_r  <= bit_r + 3'h1;
                  if (bit_r == DATA_LAST) st_r <= RX_STOP;
               end
               RX_STOP: begin
                  st_r <= RX_IDLE;
                  // Last data bit must be 0 and a stop bit present
                  if (rxd && !sh_r[ZERO_BIT]) begin
                     rx_data_r  <= sh_r;
                     rx_valid_r <= 1'b1;
                  end else begin
                     rx_err_r <= 1'b1;
                  end
               end
               default: st_r <= RX_IDLE;
            endcase
         end
      end
   end
endmodule : boot_rx

// File: flash_array.sv
// Purpose: Behavioural program flash array behind the port
// Assumes: Erased cells read FF
// Notes:   Writes land on the rising edge of the program level, or of the erase level for a full erase only
`timescale 1ns/1ns
module flash_array
   import fsp_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic [15:0] flash_addr_r,
   input  wire logic [7:0]  flash_wdata_r,
   input  wire logic        flash_prog_r,
   input  wire logic        flash_erase_r,
   input  wire logic [3:0]  flash_erase_kind_r,
   output logic [7:0]       flash_rdata
);
   logic [7:0] mem [0:65535];
   logic       prog_d = 1'b0;
   logic       erase_d = 1'b0;

   initial for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
   // Protection byte lives at SEC_ADDR, location BFFF, below the top location
   assign flash_rdata = mem[flash_addr_r];

   always @(posedge clk_sys) begin
      prog_d <= flash_prog_r;
      erase_d <= flash_erase_r;
      if (flash_prog_r && !prog_d) mem[flash_addr_r] <= flash_wdata_r;
      if (flash_erase_r && !erase_d && flash_erase_kind_r == FC_FULL_ERASE)
         for (int i = 0; i < 65536; i++) mem[i] <= 8'hFF;
   end
endmodule : flash_array

// File: flash_security_program_port.sv
// Purpose: Protection state, access gating and programming port of the program flash
// Assumes: Flash array is outside; flash_rdata follows flash_addr_r within one cycle
// Notes:   Security byte and boot straps are caught on the first edge after reset
`timescale 1ns/1ns
module flash_security_program_port
   import fsp_pkg::*;
#(
   parameter int           BYTE_CYCLES  = BYTE_WRITE_CYC,
   parameter int           ERASE_CYCLES = PAGE_ERASE_CYC,
   parameter logic [7:0]   SIG_BYTE_LO  = 8'hA5, // Arbitrary value
   parameter logic [7:0]   SIG_BYTE_HI  = 8'h5A  // Arbitrary value
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       reset_pin,
   input  wire logic       program_store_strobe_n,
   input  wire logic       external_access_n,
   input  wire logic       oscillator_select,
   input  wire logic       ctrl_a,
   input  wire logic       ctrl_b,
   input  wire logic       ctrl_c,
   input  wire logic       ctrl_d,
   input  wire logic       write_enable_strobe_n,
   input  wire logic [7:0] port1_in,
   input  wire logic [5:0] port2_in,
   input  wire logic [1:0] port3_addr_in,
   input  wire logic [7:0] port0_in,
   output logic [7:0]      port0_out_r,
   output logic            port0_oe_r,
   input  wire logic [7:0] flash_rdata,
   output logic [15:0]     flash_addr_r,
   output logic [7:0]      flash_wdata_r,
   output logic            flash_prog_r,
   output logic            flash_erase_r,
   output logic [3:0]      flash_erase_kind_r,
   input  wire logic       fetch_internal,
   input  wire logic       code_read_req,
   output logic            code_read_grant_r,
   input  wire logic       fcb_wr,
   input  wire logic [3:0] fcb_wdata,
   output logic [3:0]      function_code_field_r,
   input  wire logic       op_go,
   input  wire logic [15:0] op_addr,
   input  wire logic [7:0] op_data,
   output logic            hv_r,
   output logic            op_done_r,
   output logic            prot_r,
   output logic [1:0]      user_boot_select_r,
   output logic            boot_map_full_r,
   output logic [15:0]     exec_start_r,
   input  wire logic       boot_rxd,
   output logic [7:0]      boot_rx_data_r,
   output logic            boot_rx_valid_r,
   output logic            boot_rx_err_r
);
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_END} op_state_t;

   fsp_op_if op ();

   op_state_t    st_r;
   logic         started_r;
   logic         we_n_prev_r;
   logic         full_r;
   logic         start_r;
   logic [16:0]  cyc_r;
   logic         boot_mode_r;

   logic         par_mode;
   logic [3:0]   mode;
   logic [15:0]  pin_addr;
   logic         we_fall;
   logic         par_erase_go;
   logic         par_prog_go;
   logic         boot_go;
   logic         prot_sample;

   assign par_mode = reset_pin && !program_store_strobe_n
                     && external_access_n && oscillator_select;
   assign mode     = {ctrl_a, ctrl_b, ctrl_c, ctrl_d};
   assign pin_addr = {port3_addr_in, port2_in, port1_in};
   assign we_fall  = we_n_prev_r && !write_enable_strobe_n;
   assign par_erase_go = par_mode && we_fall && (mode == MODE_ERASE);
   assign par_prog_go  = par_mode && we_fall && (mode == MODE_PROG) && !prot_r;
   assign boot_go  = !par_mode && op_go && (function_code_field_r != FC_NONE);
   // Only the two patterns 00 and FF leave the part open
   assign prot_sample = (flash_rdata != SEC_OFF_ZERO) && (flash_rdata != SEC_OFF_ONES);

   assign op.start  = start_r;
   assign op.cycles = cyc_r;

   op_timer u_timer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .op      (op)
   );

   boot_rx u_rx (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .enable     (boot_mode_r),
      .rxd        (boot_rxd),
      .rx_data_r  (boot_rx_data_r),
      .rx_valid_r (boot_rx_valid_r),
      .rx_err_r   (boot_rx_err_r)
   );

   // First edge after reset release: catch straps and security byte
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) started_r <= 1'b0;
      else        started_r <= 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) we_n_prev_r <= 1'b1;
      else        we_n_prev_r <= write_enable_strobe_n;
   end

   // Protection state, loaded only once per reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prot_r <= 1'b1;
      end else if (!started_r) begin
         prot_r <= prot_sample;
      end else if (op.done && full_r) begin
         prot_r <= 1'b0;
      end
   end

   // Boot mode straps
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         boot_mode_r        <= 1'b0;
         user_boot_select_r <= UBS_USER;
         boot_map_full_r    <= 1'b0;
         exec_start_r       <= USER_START;
      end else if (!started_r) begin
         if (!program_store_strobe_n && !external_access_n) begin
            boot_mode_r        <= 1'b1;
            user_boot_select_r <= UBS_BOOT_FULL;
            boot_map_full_r    <= 1'b1;
            exec_start_r       <= BOOT_START;
         end
      end
   end

   // Function code field
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         function_code_field_r <= FC_NONE;
      end else if (fcb_wr) begin
         if (fetch_internal || !prot_r || fcb_wdata == FC_FULL_ERASE) begin
            function_code_field_r <= fcb_wdata;
         end
      end
   end

   // Code read gating
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) code_read_grant_r <= 1'b0;
      else        code_read_grant_r <= code_read_req && (fetch_internal || !prot_r);
   end

   // Operation sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r               <= ST_IDLE;
         start_r            <= 1'b0;
         cyc_r              <= '0;
         full_r             <= 1'b0;
         flash_prog_r       <= 1'b0;
         flash_erase_r      <= 1'b0;
         flash_erase_kind_r <= FC_NONE;
         flash_wdata_r      <= DATA_IDLE;
         hv_r               <= 1'b0;
         op_done_r          <= 1'b0;
      end else begin
         start_r   <= 1'b0;
         op_done_r <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (started_r && par_erase_go) begin
                  // One strobe, one erase
                  st_r               <= ST_RUN;
                  start_r            <= 1'b1;
                  cyc_r              <= CNT_W'(ERASE_CYCLES);
                  full_r             <= 1'b1;
                  flash_erase_r      <= 1'b1;
                  flash_erase_kind_r <= FC_FULL_ERASE;
                  hv_r               <= 1'b1;
               end else if (started_r && par_prog_go) begin
                  st_r          <= ST_RUN;
                  start_r       <= 1'b1;
                  cyc_r         <= CNT_W'(BYTE_CYCLES);
                  full_r        <= 1'b0;
                  flash_prog_r  <= 1'b1;
                  flash_wdata_r <= port0_in;
                  hv_r          <= 1'b1;
               end else if (started_r && boot_go) begin
                  st_r    <= ST_RUN;
                  start_r <= 1'b1;
                  hv_r    <= 1'b1;
                  full_r  <= (function_code_field_r == FC_FULL_ERASE);
                  if (function_code_field_r == FC_BYTE) begin
                     cyc_r         <= CNT_W'(BYTE_CYCLES);
                     flash_prog_r  <= 1'b1;
                     flash_wdata_r <= op_data;
                  end else begin
                     cyc_r              <= CNT_W'(ERASE_CYCLES);
                     flash_erase_r      <= 1'b1;
                     flash_erase_kind_r <= function_code_field_r;
                  end
               end
            end
            ST_RUN: begin
               if (op.done) begin
                  st_r               <= ST_END;
                  flash_prog_r       <= 1'b0;
                  flash_erase_r      <= 1'b0;
                  flash_erase_kind_r <= FC_NONE;
                  hv_r               <= 1'b0;
                  op_done_r          <= 1'b1;
               end
            end
            ST_END: begin
               // Wait for the strobe to rise before another parallel op
               if (write_enable_strobe_n || !par_mode) st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // Flash address: security byte first, then pins or boot call
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flash_addr_r <= SEC_ADDR;
      end else if (st_r == ST_IDLE && started_r) begin
         if (par_mode) flash_addr_r <= pin_addr;
         else          flash_addr_r <= op_addr;
      end
   end

   // Port 0 read-back for verify and signature
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         port0_out_r <= DATA_IDLE;
         port0_oe_r  <= 1'b0;
      end else if (par_mode && write_enable_strobe_n && mode == MODE_SIG) begin
         port0_oe_r <= 1'b1;
         if (pin_addr == SIG_ADDR_LO)      port0_out_r <= SIG_BYTE_LO;
         else if (pin_addr == SIG_ADDR_HI) port0_out_r <= SIG_BYTE_HI;
         else                              port0_out_r <= DATA_IDLE;
      end else if (par_mode && write_enable_strobe_n && mode == MODE_VERIFY
                   && !prot_r && st_r == ST_IDLE) begin
         port0_oe_r  <= 1'b1;
         port0_out_r <= flash_rdata;
      end else begin
         port0_oe_r  <= 1'b0;
         port0_out_r <= DATA_IDLE;
      end
   end
endmodule : flash_security_program_port

// File: fsp_op_if.sv
// Purpose: Carrier between the operation sequencer and its duration timer
// Assumes: One operation at a time
// Notes:   done is a one-cycle pulse at the end of busy
`timescale 1ns/1ns
interface fsp_op_if;
   logic                 start;
   logic [16:0]          cycles;
   logic                 busy;
   logic                 done;
   modport ctrl (output start, output cycles, input busy, input done);
   modport tmr  (input start, input cycles, output busy, output done);
endinterface : fsp_op_if

// File: fsp_pkg.sv
// Purpose: Shared constants for the flash protection and programming port
// Assumes: clk_sys at 20 MHz
// Notes:   Mode patterns are ordered {ctrl_a, ctrl_b, ctrl_c, ctrl_d}
package fsp_pkg;
   localparam logic [15:0] SEC_ADDR      = 16'hBFFF;
   localparam logic [7:0]  SEC_ON        = 8'h50;
   localparam logic [7:0]  SEC_OFF_ZERO  = 8'h00;
   localparam logic [7:0]  SEC_OFF_ONES  = 8'hFF;
   localparam logic [15:0] SIG_ADDR_LO   = 16'h0030;
   localparam logic [15:0] SIG_ADDR_HI   = 16'h0031;
   localparam logic [15:0] BOOT_START    = 16'h0000;
   localparam logic [15:0] USER_START    = 16'h0000;
   localparam logic [1:0]  UBS_BOOT_FULL = 2'h3;
   localparam logic [1:0]  UBS_USER      = 2'h0;
   localparam logic [7:0]  DATA_IDLE     = 8'h00;

   // Function codes
   localparam logic [3:0] FC_NONE        = 4'h0;
   localparam logic [3:0] FC_BYTE        = 4'h5;
   localparam logic [3:0] FC_PAGE_ERASE  = 4'hC;
   localparam logic [3:0] FC_BLOCK_ERASE = 4'h3;
   localparam logic [3:0] FC_FULL_ERASE  = 4'hA;

   // Parallel mode control patterns
   localparam logic [3:0] MODE_ERASE  = 4'hD;
   localparam logic [3:0] MODE_PROG   = 4'hB;
   localparam logic [3:0] MODE_VERIFY = 4'h3;
   localparam logic [3:0] MODE_SIG    = 4'h0;

   // Timing
   localparam int CLK_HZ          = 20_000_000;
   localparam int BYTE_WRITE_US   = 2500;
   localparam int PAGE_ERASE_US   = 5000;
   localparam int BYTE_WRITE_CYC  = BYTE_WRITE_US * (CLK_HZ / 1_000_000);
   localparam int PAGE_ERASE_CYC  = PAGE_ERASE_US * (CLK_HZ / 1_000_000);
   localparam int CNT_W           = 17;
   localparam int BAUD            = 9600;
   localparam int BIT_CYC         = CLK_HZ / BAUD;
   localparam int BAUD_W          = 12;
   localparam logic [BAUD_W-1:0] BIT_LAST  = BAUD_W'(BIT_CYC - 1);
   localparam logic [BAUD_W-1:0] HALF_LAST = BAUD_W'(BIT_CYC / 2 - 1);
   localparam int DATA_BITS       = 8;
   localparam logic [2:0] DATA_LAST = 3'h7;
   localparam int ZERO_BIT        = 7;
endpackage : fsp_pkg

// File: fsp_sva.sv
// Purpose: Temporal checks on the flash protection and programming port
// Assumes: One clock domain, rst_n asynchronous and active low
// Notes:   Bound to the top module, sees its ports only
`timescale 1ns/1ns
module fsp_sva
   import fsp_pkg::*;
#(
   parameter int         BYTE_CYCLES  = 20,
   parameter int         ERASE_CYCLES = 40,
   parameter logic [7:0] SIG_BYTE_LO  = 8'hA5 // Arbitrary value
)
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        reset_pin,
   input wire logic        program_store_strobe_n,
   input wire logic        external_access_n,
   input wire logic        oscillator_select,
   input wire logic        ctrl_a,
   input wire logic        ctrl_b,
   input wire logic        ctrl_c,
   input wire logic        ctrl_d,
   input wire logic        write_enable_strobe_n,
   input wire logic [7:0]  port1_in,
   input wire logic [5:0]  port2_in,
   input wire logic [1:0]  port3_addr_in,
   input wire logic [7:0]  port0_in,
   input wire logic [7:0]  port0_out_r,
   input wire logic        port0_oe_r,
   input wire logic [15:0] flash_addr_r,
   input wire logic [7:0]  flash_wdata_r,
   input wire logic        flash_prog_r,
   input wire logic        flash_erase_r,
   input wire logic        fetch_internal,
   input wire logic        code_read_req,
   input wire logic        code_read_grant_r,
   input wire logic        hv_r,
   input wire logic        op_done_r,
   input wire logic        prot_r,
   input wire logic [1:0]  user_boot_select_r,
   input wire logic        boot_map_full_r
);
   logic [1:0]  up_r;
   logic [16:0] cnt_r;
   wire         par   = reset_pin && !program_store_strobe_n && external_access_n
                        && oscillator_select;
   wire [3:0]   pat   = {ctrl_a, ctrl_b, ctrl_c, ctrl_d};
   wire [15:0]  pins  = {port3_addr_in, port2_in, port1_in};
   wire         cr_ok = code_read_req && (fetch_internal || !prot_r);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Edges since reset, first two carry the reset-time sampling
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) up_r <= 2'h0;
      else if (up_r != 2'h2) up_r <= up_r + 2'h1;
   end

   // Length of the current busy stretch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) cnt_r <= 17'h0;
      else cnt_r <= hv_r ? cnt_r + 17'h1 : 17'h0;
   end

   sequence strobe_fall(logic [3:0] m);
      up_r == 2'h2 && par && pat == m && $fell(write_enable_strobe_n) && !hv_r;
   endsequence
   sequence sig_at(logic [15:0] a);
      up_r == 2'h2 && par && pat == MODE_SIG && write_enable_strobe_n && pins == a;
   endsequence

   grant_gate_a: assert property (up_r != 2'h0 |-> code_read_grant_r == $past(cr_ok))
      else $error("code read grant wrong");
   prog_start_a: assert property (strobe_fall(MODE_PROG) ##0 !prot_r |=> hv_r
      && flash_prog_r && flash_addr_r == $past(pins) && flash_wdata_r == $past(port0_in))
      else $error("program start wrong");
   prog_block_a: assert property (strobe_fall(MODE_PROG) ##0 prot_r |=> !hv_r)
      else $error("program not blocked");
   erase_start_a: assert property (strobe_fall(MODE_ERASE) |=> hv_r && flash_erase_r)
      else $error("erase not started");
   op_length_a: assert property (op_done_r |-> cnt_r ==
      17'($past(flash_prog_r) ? BYTE_CYCLES + 2 : ERASE_CYCLES + 2))
      else $error("operation length wrong");
   done_pulse_a: assert property ($fell(hv_r) |-> op_done_r ##1 !op_done_r)
      else $error("done pulse wrong");
   prot_clear_a: assert property (up_r == 2'h2 && $changed(prot_r) |-> !prot_r && op_done_r)
      else $error("protection changed wrongly");
   verify_block_a: assert property (up_r == 2'h2 && par && pat == MODE_VERIFY
      && write_enable_strobe_n && prot_r |=> !port0_oe_r)
      else $error("verify not blocked");
   sig_read_a: assert property (sig_at(SIG_ADDR_LO) [*2] |=> port0_oe_r
      && port0_out_r == SIG_BYTE_LO)
      else $error("signature byte wrong");
   boot_strap_a: assert property ($rose(rst_n) && !program_store_strobe_n
      && !external_access_n |=> user_boot_select_r == UBS_BOOT_FULL && boot_map_full_r)
      else $error("boot straps not taken");
endmodule : fsp_sva

bind flash_security_program_port fsp_sva #(.BYTE_CYCLES(BYTE_CYCLES),
   .ERASE_CYCLES(ERASE_CYCLES), .SIG_BYTE_LO(SIG_BYTE_LO)) chk (.*);

// File: op_timer.sv
// Purpose: Fixed-length duration timer for write and erase operations
// Assumes: start is ignored while busy
// Notes:   busy stands for exactly cycles clocks
`timescale 1ns/1ns
module op_timer
   import fsp_pkg::*;
(
   input  wire logic    clk_sys,
   input  wire logic    rst_n,
   fsp_op_if.tmr        op
);
   logic [CNT_W-1:0] cnt_r;
   logic             busy_r;
   logic             done_r;

   assign op.busy = busy_r;
   assign op.done = done_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (!busy_r && op.start) begin
            cnt_r  <= op.cycles - CNT_W'(1);
            busy_r <= 1'b1;
         end else if (busy_r) begin
            if (cnt_r == '0) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r - CNT_W'(1);
            end
         end
      end
   end
endmodule : op_timer

// File: testbench.sv
// Purpose: Self-checking bench for the flash protection and programming port
// Assumes: Shortened operation counts
// Notes:   Parallel mode pins held steady except in the boot test
`timescale 1ns/1ns
module testbench;
   import fsp_pkg::*;
   localparam int         BC     = 20;
   localparam int         EC     = 40;
   localparam logic [7:0] SIG_LO = 8'hC3; // Arbitrary value
   localparam logic [7:0] SIG_HI = 8'h3C; // Arbitrary value
   logic clk_sys = 1'b0, rst_n = 1'b0, reset_pin = 1'b1, program_store_strobe_n = 1'b0;
   logic external_access_n = 1'b1, oscillator_select = 1'b1, write_enable_strobe_n = 1'b1;
   logic ctrl_a = 1'b0, ctrl_b = 1'b0, ctrl_c = 1'b0, ctrl_d = 1'b0, boot_rxd = 1'b1;
   logic [7:0] port1_in = 8'h00, port0_in = 8'h00, op_data = 8'h00;
   logic [5:0] port2_in = 6'h00;
   logic [1:0] port3_addr_in = 2'h0;
   logic fetch_internal = 1'b0, code_read_req = 1'b0, fcb_wr = 1'b0, op_go = 1'b0;
   logic [3:0] fcb_wdata = 4'h0;
   logic [15:0] op_addr = 16'h0000;
   logic [7:0] port0_out_r, flash_rdata, flash_wdata_r, boot_rx_data_r;
   logic [15:0] flash_addr_r, exec_start_r;
   logic [3:0] flash_erase_kind_r, function_code_field_r;
   logic [1:0] user_boot_select_r;
   logic port0_oe_r, flash_prog_r, flash_erase_r, code_read_grant_r, hv_r, op_done_r;
   logic prot_r, boot_map_full_r, boot_rx_valid_r, boot_rx_err_r;
   int errors = 0;
   int samples_checked = 0;

   always #25 clk_sys = ~clk_sys;

   flash_security_program_port #(.BYTE_CYCLES(BC), .ERASE_CYCLES(EC),
      .SIG_BYTE_LO(SIG_LO), .SIG_BYTE_HI(SIG_HI)) uut (.*);
   flash_array flash (.*);

   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
         errors++;
      end
   endtask : check

   task automatic do_reset;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask : do_reset

   // Counts falling edges from the launching edge to the done pulse
   task automatic wait_done(input int n);
      int k;
      k = 0;
      while (op_done_r !== 1'b1 && k < 400) begin
         @(negedge clk_sys);
         k++;
      end
      if (k == 400) begin
         errors++;
         print_verdict();
      end else begin
         check(16'(k), 16'(n));
      end
   endtask : wait_done

   task automatic set_pins(input logic [3:0] m, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      {ctrl_a, ctrl_b, ctrl_c, ctrl_d} <= m;
      {port3_addr_in, port2_in, port1_in} <= a;
      port0_in <= d;
   endtask : set_pins

   // Strobed operation, n is the operation length in cycles, four below the expected count, or 0 for a refused one
   task automatic op(input logic [3:0] m, input logic [15:0] a, input logic [7:0] d, input int n);
      set_pins(m, a, d);
      repeat (48) @(posedge clk_sys);
      write_enable_strobe_n <= 1'b0;
      if (n == 0) begin
         repeat (3) @(negedge clk_sys);
         check(hv_r, 1'b0);
      end
      else wait_done(n + 4);
      @(posedge clk_sys);
      write_enable_strobe_n <= 1'b1;
      repeat (48) @(posedge clk_sys);
   endtask : op

   task automatic rd(input logic [3:0] m, input logic [15:0] a, input logic oe, input logic [7:0] d);
      set_pins(m, a, 8'h00);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(port0_oe_r, oe);
      if (oe) check(port0_out_r, d);
   endtask : rd

   task automatic fw(input logic fi, input logic [3:0] v, input logic [3:0] exp);
      @(posedge clk_sys);
      fetch_internal <= fi;
      fcb_wr <= 1'b1;
      fcb_wdata <= v;
      @(posedge clk_sys);
      fcb_wr <= 1'b0;
      @(negedge clk_sys);
      check(function_code_field_r, exp);
   endtask : fw

   task automatic cr(input logic fi, input logic exp);
      @(posedge clk_sys);
      fetch_internal <= fi;
      code_read_req <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(code_read_grant_r, exp);
   endtask : cr

   task automatic send(input logic [7:0] b, input logic v, input logic e);
      logic [10:0] fr;
      logic [7:0]  gd;
      logic        gv;
      logic        ge;
      fr = {2'b11, b, 1'b0};
      gv = 1'b0;
      ge = 1'b0;
      gd = 8'h00;
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_sys);
         boot_rxd <= fr[i];
         repeat (BIT_CYC) begin
            @(negedge clk_sys);
            if (boot_rx_valid_r === 1'b1) gv = 1'b1;
            if (boot_rx_valid_r === 1'b1) gd = boot_rx_data_r;
            if (boot_rx_err_r === 1'b1) ge = 1'b1;
         end
      end
      check(gv, v);
      check(ge, e);
      if (v) check(gd, b);
   endtask : send

   initial begin
      @(negedge clk_sys);
      flash.mem[SEC_ADDR] = SEC_ON;
      do_reset();
      check(prot_r, 1'b1);
      rd(MODE_VERIFY, 16'h1263, 1'b0, 8'h00);
      op(MODE_PROG, 16'h1263, 8'h11, 0);
      cr(1'b0, 1'b0);
      cr(1'b1, 1'b1);
      fw(1'b0, FC_BYTE, FC_NONE);
      fw(1'b1, FC_BYTE, FC_BYTE);
      fw(1'b0, FC_FULL_ERASE, FC_FULL_ERASE);
      op(MODE_ERASE, 16'h0000, 8'h00, EC);
      check(prot_r, 1'b0);
      $display("test protected done");
      do_reset();
      check(prot_r, 1'b0);
      op(MODE_PROG, 16'hD263, 8'h3C, BC);
      rd(MODE_VERIFY, 16'hD263, 1'b1, 8'h3C);
      rd(MODE_SIG, SIG_ADDR_LO, 1'b1, SIG_LO);
      rd(MODE_SIG, SIG_ADDR_HI, 1'b1, SIG_HI);
      op(MODE_PROG, SEC_ADDR, 8'h51, BC);
      check(prot_r, 1'b0);
      do_reset();
      check(prot_r, 1'b1);
      $display("test parallel done");
      @(posedge clk_sys);
      reset_pin <= 1'b0;
      external_access_n <= 1'b0;
      do_reset();
      check(user_boot_select_r, UBS_BOOT_FULL);
      check(boot_map_full_r, 1'b1);
      check(exec_start_r, BOOT_START);
      fw(1'b1, FC_BYTE, FC_BYTE);
      @(posedge clk_sys);
      op_addr <= 16'h0040;
      op_data <= 8'h9A;
      @(posedge clk_sys);
      op_go <= 1'b1;
      @(posedge clk_sys);
      op_go <= 1'b0;
      wait_done(BC + 3);
      check(flash.mem[16'h0040], 8'h9A);
      fw(1'b1, FC_PAGE_ERASE, FC_PAGE_ERASE);
      @(posedge clk_sys);
      op_go <= 1'b1;
      @(posedge clk_sys);
      op_go <= 1'b0;
      @(negedge clk_sys);
      check(flash_erase_kind_r, FC_PAGE_ERASE);
      wait_done(EC + 2);
      send(8'h35, 1'b1, 1'b0);
      send(8'hB5, 1'b0, 1'b1);
      $display("test boot done");
      print_verdict();
   end
endmodule : testbench
